// ### src/ufl_pkg.sv
package ufl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] UFL_IDX_FIFO_LEVEL_THRESHOLD = 8'hBD;
  localparam logic [7:0] UFL_IDX_DATA_PORT = 8'hBE;
  localparam logic [7:0] UFL_IDX_CTRL = 8'hC0;
  localparam logic [7:0] UFL_IDX_INT_STATUS = 8'hC1;
  localparam logic [7:0] UFL_IDX_INT_MASK = 8'hC2;

  // Field positions of fifo_level_threshold
  localparam int UFL_RX_FIELD_LSB = 4;
  localparam int UFL_TX_FIELD_LSB = 0;
  localparam int UFL_FIELD_W = 4;

  // Control register
  localparam int UFL_CTRL_ENABLE_BIT = 0;

  // Interrupt status and mask layout
  localparam int UFL_IRQ_W = 5;
  localparam int UFL_IRQ_RX_AVAIL_BIT = 0;
  localparam int UFL_IRQ_TX_READY_BIT = 1;
  localparam int UFL_IRQ_RX_OVF_BIT = 2;
  localparam int UFL_IRQ_RX_UNF_BIT = 3;
  localparam int UFL_IRQ_TX_OVF_BIT = 4;

  // Values after reset
  localparam logic [3:0] UFL_RST_RX_THRESHOLD = 4'h0;
  localparam logic [3:0] UFL_RST_TX_THRESHOLD = 4'h0;
  localparam logic [7:0] UFL_RST_DATA = 8'h00;
  localparam logic UFL_RST_ENABLE = 1'b0;
  localparam logic [4:0] UFL_RST_IRQ = 5'h00;

  // Depth of each FIFO in bytes
  localparam int UFL_FIFO_DEPTH = 4;
  localparam int UFL_BYTE_W = 8;

  // Bus phase, one-hot
  typedef enum logic [1:0] {
    UFL_BUS_IDLE = 2'b01,
    UFL_BUS_ACK = 2'b10
  } ufl_bus_t;

  typedef struct packed {
    logic tx_overflow_flag;
    logic rx_underflow_flag;
    logic rx_overflow_flag;
    logic tx_ready;
    logic rx_data_available;
  } ufl_irq_t;

  // Byte stream from or to the serializer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ufl_byte_t;

endpackage : ufl_pkg

// ### src/ufl_fifo.sv
`timescale 1ns/1ps

module ufl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int CNT_W = $clog2(DEPTH + 1),
  parameter int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head_data,
  output logic [CNT_W-1:0] count,
  output logic full,
  output logic empty
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
  } fifo_state_t;

  fifo_state_t st_q;
  fifo_state_t st_d;
  logic do_push;
  logic do_pop;

  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
    // Wrap explicitly so depths that are not powers of two still work
    if (p == PTR_W'(DEPTH - 1))
      return '0;
    return PTR_W'(p + 1'b1);
  endfunction : ptr_next

  assign full = (st_q.count == CNT_W'(DEPTH));
  assign empty = (st_q.count == '0);
  assign count = st_q.count;
  assign head_data = st_q.mem[st_q.rd_ptr];
  // Push while full or pop while empty is dropped here; the caller flags it
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  always_comb
  begin
    st_d = st_q;
    if (flush)
    begin
      st_d.wr_ptr = '0;
      st_d.rd_ptr = '0;
      st_d.count = '0;
    end
    else
    begin
      if (do_push)
      begin
        st_d.mem[st_q.wr_ptr] = push_data;
        st_d.wr_ptr = ptr_next(st_q.wr_ptr);
      end
      if (do_pop)
        st_d.rd_ptr = ptr_next(st_q.rd_ptr);
      if (do_push && !do_pop)
        st_d.count = CNT_W'(st_q.count + 1'b1);
      else if (do_pop && !do_push)
        st_d.count = CNT_W'(st_q.count - 1'b1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      st_q <= '0;
    else if (ce)
      st_q <= st_d;
  end

endmodule : ufl_fifo

// ### src/ufl_top.sv
`timescale 1ns/1ps

module ufl_top #(
  parameter int ADDR_W = 10,
  parameter int DEPTH = ufl_pkg::UFL_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ufl_pkg::ufl_byte_t rx_in,
  output ufl_pkg::ufl_byte_t tx_out,
  input wire logic tx_taken,
  output logic rx_data_available,
  output logic tx_ready,
  output logic irq
);

  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    ufl_pkg::ufl_bus_t bus;
    logic [7:0] rdata;
    logic uart_enable;
    logic [3:0] rx_trigger_threshold;
    logic [3:0] tx_trigger_threshold;
    ufl_pkg::ufl_irq_t status;
    ufl_pkg::ufl_irq_t mask;
  } top_state_t;

  top_state_t st_q;
  top_state_t st_d;

  logic [7:0] reg_idx;
  logic req;
  logic wr_lo;
  logic rd_cyc;
  logic hit_lvl;
  logic hit_data;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic flush;
  logic rx_push;
  logic rx_pop;
  logic tx_push;
  logic tx_pop;
  logic [7:0] rx_head;
  logic [7:0] tx_head;
  logic [CNT_W-1:0] rx_cnt;
  logic [CNT_W-1:0] tx_cnt;
  logic rx_full;
  logic rx_empty;
  logic tx_full;
  logic tx_empty;
  logic [3:0] rx_fill_count;
  logic [3:0] tx_fill_count;
  ufl_pkg::ufl_irq_t events;
  ufl_pkg::ufl_irq_t w1c;

  // Word addressing: byte lanes 1:0 of the address are ignored
  assign reg_idx = wb_adr_i[9:2];
  assign req = wb_cyc_i && wb_stb_i && (st_q.bus == ufl_pkg::UFL_BUS_IDLE);
  assign wr_lo = req && wb_we_i && wb_sel_i[0];
  assign rd_cyc = req && !wb_we_i;
  assign hit_lvl = (reg_idx == ufl_pkg::UFL_IDX_FIFO_LEVEL_THRESHOLD);
  assign hit_data = (reg_idx == ufl_pkg::UFL_IDX_DATA_PORT);
  assign hit_ctrl = (reg_idx == ufl_pkg::UFL_IDX_CTRL);
  assign hit_stat = (reg_idx == ufl_pkg::UFL_IDX_INT_STATUS);
  assign hit_mask = (reg_idx == ufl_pkg::UFL_IDX_INT_MASK);

  // Clear on every write of zero to the enable, not only on its falling edge
  assign flush = wr_lo && hit_ctrl && !wb_dat_i[ufl_pkg::UFL_CTRL_ENABLE_BIT];

  assign rx_push = st_q.uart_enable && rx_in.valid;
  assign rx_pop = rd_cyc && hit_data;
  assign tx_push = wr_lo && hit_data;
  assign tx_pop = st_q.uart_enable && tx_taken && !tx_empty;

  ufl_fifo #(
    .WIDTH(ufl_pkg::UFL_BYTE_W),
    .DEPTH(DEPTH)
  ) u_rx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .flush(flush),
    .push(rx_push),
    .push_data(rx_in.data),
    .pop(rx_pop),
    .head_data(rx_head),
    .count(rx_cnt),
    .full(rx_full),
    .empty(rx_empty)
  );

  ufl_fifo #(
    .WIDTH(ufl_pkg::UFL_BYTE_W),
    .DEPTH(DEPTH)
  ) u_tx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .flush(flush),
    .push(tx_push),
    .push_data(wb_dat_i[7:0]),
    .pop(tx_pop),
    .head_data(tx_head),
    .count(tx_cnt),
    .full(tx_full),
    .empty(tx_empty)
  );

  assign rx_fill_count = 4'(rx_cnt);
  assign tx_fill_count = 4'(tx_cnt);

  // Reserved codes are stored as written; compare treats them as plain numbers
  assign rx_data_available = (rx_fill_count > st_q.rx_trigger_threshold);
  // Threshold code 0 on transmit never raises ready
  assign tx_ready = (tx_fill_count < st_q.tx_trigger_threshold);

  // One driver for the whole struct keeps strict tools happy
  assign tx_out = '{valid: st_q.uart_enable && !tx_empty, data: tx_head};

  always_comb
  begin
    events.rx_data_available = rx_data_available;
    events.tx_ready = tx_ready;
    events.rx_overflow_flag = rx_push && rx_full;
    events.rx_underflow_flag = rx_pop && rx_empty;
    events.tx_overflow_flag = tx_push && tx_full;
  end

  assign w1c = (wr_lo && hit_stat) ? ufl_pkg::ufl_irq_t'(wb_dat_i[4:0]) : '0;

  always_comb
  begin
    st_d = st_q;
    st_d.bus = ufl_pkg::UFL_BUS_IDLE;
    if (req)
    begin
      // Answer one cycle after the request; the ack drops the cycle after
      st_d.bus = ufl_pkg::UFL_BUS_ACK;
      st_d.rdata = 8'h00;
      if (!wb_we_i)
      begin
        if (hit_lvl)
          st_d.rdata = {rx_fill_count, tx_fill_count};
        else if (hit_data)
          st_d.rdata = rx_empty ? ufl_pkg::UFL_RST_DATA : rx_head;
        else if (hit_ctrl)
          st_d.rdata = {7'h00, st_q.uart_enable};
        else if (hit_stat)
          st_d.rdata = {3'h0, st_q.status};
        else if (hit_mask)
          st_d.rdata = {3'h0, st_q.mask};
      end
    end
    if (wr_lo && hit_lvl)
    begin
      st_d.rx_trigger_threshold = wb_dat_i[ufl_pkg::UFL_RX_FIELD_LSB +: ufl_pkg::UFL_FIELD_W];
      st_d.tx_trigger_threshold = wb_dat_i[ufl_pkg::UFL_TX_FIELD_LSB +: ufl_pkg::UFL_FIELD_W];
    end
    if (wr_lo && hit_ctrl)
      st_d.uart_enable = wb_dat_i[ufl_pkg::UFL_CTRL_ENABLE_BIT];
    if (wr_lo && hit_mask)
      st_d.mask = ufl_pkg::ufl_irq_t'(wb_dat_i[4:0]);
    // Write one to clear, then events set; a set in the clear cycle wins
    st_d.status = st_q.status & ~w1c;
    if (flush)
    begin
      st_d.status.rx_overflow_flag = 1'b0;
      st_d.status.rx_underflow_flag = 1'b0;
      st_d.status.tx_overflow_flag = 1'b0;
    end
    st_d.status = st_d.status | events;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_q.bus <= ufl_pkg::UFL_BUS_IDLE;
      st_q.rdata <= ufl_pkg::UFL_RST_DATA;
      st_q.uart_enable <= ufl_pkg::UFL_RST_ENABLE;
      st_q.rx_trigger_threshold <= ufl_pkg::UFL_RST_RX_THRESHOLD;
      st_q.tx_trigger_threshold <= ufl_pkg::UFL_RST_TX_THRESHOLD;
      st_q.status <= ufl_pkg::ufl_irq_t'(ufl_pkg::UFL_RST_IRQ);
      st_q.mask <= ufl_pkg::ufl_irq_t'(ufl_pkg::UFL_RST_IRQ);
    end
    else if (ce)
      st_q <= st_d;
  end

  assign wb_ack_o = (st_q.bus == ufl_pkg::UFL_BUS_ACK);
  assign wb_dat_o = {24'h000000, st_q.rdata};
  assign irq = |(st_q.status & st_q.mask);

endmodule : ufl_top

// ### dv/ufl_props.sv
`timescale 1ns/1ps
module ufl_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire ufl_pkg::ufl_byte_t rx_in,
  input wire ufl_pkg::ufl_byte_t tx_out,
  input wire logic tx_taken,
  input wire logic rx_data_available,
  input wire logic tx_ready,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence bus_take;
    ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_answer_a: assert property (bus_take |=> ack_once)
    else $error("ack not a single pulse after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_lane_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=>
    !wb_ack_o && !tx_out.valid && !tx_ready && !irq && !rx_data_available)
    else $error("outputs not quiet after reset");
  tx_hold_a: assert property (tx_out.valid && !tx_taken
    && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> tx_out.valid && $stable(tx_out.data))
    else $error("transmit head changed without pop");
  tx_rise_a: assert property ($rose(tx_ready)
    |-> $past(tx_taken || (wb_cyc_i && wb_stb_i && wb_we_i)))
    else $error("tx ready rose without pop or write");
  tx_fall_a: assert property ($fell(tx_ready) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("tx ready fell without write");
  rx_rise_a: assert property ($rose(rx_data_available)
    |-> $past(rx_in.valid || (wb_cyc_i && wb_stb_i && wb_we_i)))
    else $error("rx available rose without byte or write");
  rx_fall_a: assert property ($fell(rx_data_available) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("rx available fell without access");
endmodule : ufl_props
bind ufl_top ufl_props u_props (.ref_clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_dat_o, .wb_ack_o, .rx_in, .tx_out, .tx_taken, .rx_data_available, .tx_ready, .irq);

// ### dv/ufl_link_model.sv
`timescale 1ns/1ps
module ufl_link_model (
  input wire logic ref_clk,
  input wire ufl_pkg::ufl_byte_t tx_out,
  output ufl_pkg::ufl_byte_t rx_in,
  output logic tx_taken
);
  int gap = 3;
  int wait_n = 0;
  logic [7:0] got[$];
  initial
  begin
    rx_in = '0;
    tx_taken = 1'b0;
  end
  // Slow taker: head must stay put while it waits
  always @(posedge ref_clk)
  begin
    if (tx_taken && tx_out.valid)
      got.push_back(tx_out.data);
    wait_n <= (tx_out.valid && !tx_taken) ? wait_n + 1 : 0;
    tx_taken <= tx_out.valid && !tx_taken && wait_n >= gap;
  end
  // Idle data is inverted so a stale byte is never re-read
  task automatic send(input logic [7:0] d);
    @(posedge ref_clk);
    rx_in <= '{valid: 1'b1, data: d};
    @(posedge ref_clk);
    rx_in <= '{valid: 1'b0, data: ~d};
    @(posedge ref_clk);
  endtask : send
endmodule : ufl_link_model

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic tx_taken;
  logic rx_av;
  logic tx_rdy;
  logic irq;
  ufl_pkg::ufl_byte_t rx_in;
  ufl_pkg::ufl_byte_t tx_out;
  int err_total = 0;
  int checked = 0;
  localparam logic [9:0] A_LVL = 10'h2F4;
  localparam logic [9:0] A_DAT = 10'h2F8;
  localparam logic [9:0] A_CTL = 10'h300;
  localparam logic [9:0] A_ST = 10'h304;
  localparam logic [9:0] A_MSK = 10'h308;
  always #10 ref_clk = ~ref_clk;
  ufl_top dut (.ref_clk, .rst_n, .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .rx_in, .tx_out, .tx_taken, .rx_data_available(rx_av), .tx_ready(tx_rdy), .irq);
  ufl_link_model link (.ref_clk, .tx_out, .rx_in, .tx_taken);
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
    output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    sel <= 4'hF;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
    begin
      err_total++;
      give_verdict();
    end
  endtask : xfer
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    chk("read data", q, {24'h0, e});
  endtask : rd
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(A_LVL, 8'h00);
    rd(A_ST, 8'h00);
    rd(10'h3FC, 8'h00);
    wr(A_LVL, 8'h24);
    rd(A_LVL, 8'h00);
    chk("tx_ready", tx_rdy, 1'h1);
    chk("rx_avail", rx_av, 1'h0);
    $display("test thresholds done");
    // Fifth push must be refused
    for (int i = 0; i < 5; i++)
    begin
      wr(A_DAT, 8'(8'hA0 + i));
      chk("tx_ready", tx_rdy, i < 3);
    end
    rd(A_LVL, 8'h04);
    rd(A_ST, 8'h12);
    wr(A_ST, 8'h10);
    rd(A_ST, 8'h02);
    wr(A_CTL, 8'h01);
    for (int n = 0; n < 200 && link.got.size() < 4; n++)
      @(posedge ref_clk);
    if (link.got.size() < 4)
    begin
      err_total++;
      give_verdict();
    end
    for (int i = 0; i < 4; i++)
      chk("tx byte", link.got[i], 8'(8'hA0 + i));
    rd(A_LVL, 8'h00);
    $display("test transmit done");
    for (int i = 1; i < 4; i++)
      link.send(8'(8'h50 + i));
    chk("rx_avail", rx_av, 1'h1);
    rd(A_LVL, 8'h30);
    rd(A_DAT, 8'h51);
    chk("rx_avail", rx_av, 1'h0);
    rd(A_DAT, 8'h52);
    rd(A_DAT, 8'h53);
    rd(A_DAT, 8'h00);
    $display("test receive done");
    for (int i = 0; i < 5; i++)
      link.send(8'(8'h60 + i));
    rd(A_LVL, 8'h40);
    rd(A_DAT, 8'h60);
    wr(A_MSK, 8'h0C);
    chk("irq", irq, 1'h1);
    wr(A_CTL, 8'h00);
    rd(A_LVL, 8'h00);
    chk("irq", irq, 1'h0);
    rd(A_ST, 8'h03);
    $display("test flush done");
    // Transmit code one and receive code zero
    wr(A_LVL, 8'h01);
    chk("tx_ready", tx_rdy, 1'h1);
    chk("rx_avail", rx_av, 1'h0);
    wr(A_DAT, 8'h77);
    chk("tx_ready", tx_rdy, 1'h0);
    rd(A_LVL, 8'h01);
    $display("test threshold codes done");
    give_verdict();
  end
endmodule : testbench
